// file: core/adc_seq_consts.svh
// register offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
`define OFF_CTRL0 5'h00
`define OFF_CTRL1 5'h04
`define OFF_RES_HI 5'h08
`define OFF_RES_LO 5'h0c
`define OFF_IRQ_FLAG 5'h10
`define OFF_IRQ_EN 5'h14
`define CTRL0_EN_BIT 0
`define CTRL0_GO_BIT 1
`define CTRL0_CHS_LSB 2
`define CTRL0_CKS_LSB 6
`define CTRL1_JUST_BIT 7
`define FLAG_DONE_BIT 0
`define EN_DONE_BIT 0
`define CTRL0_RESET 8'h00
`define CTRL1_RESET 8'h00
`define CKS_DIV2 2'h0
`define CKS_DIV8 2'h1
`define CKS_DIV32 2'h2
`define CKS_RC 2'h3
`define DIV2_LAST 5'h01
`define DIV8_LAST 5'h07
`define DIV32_LAST 5'h1f
`define CLK_PERIOD_NS 5
`define INSN_CLOCKS 4
`define INSN_LAST 3'h3
`define CONV_LAST_TAD 4'ha
`define ABORT_LAST_TAD 1'b1
`define SAR_START 10'h200
`endif

// file: core/adc_seq_pkg.sv
// types shared by the conversion sequencer
package adc_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CONV,
    ST_ABORT
  } conv_state_e;
  typedef struct packed {
    logic [1:0] clock_sel;
    logic [3:0] channel_sel;
    logic go;
    logic enable;
  } ctrl0_s;
endpackage : adc_seq_pkg

// file: core/adc_conversion_sequencer.sv
// conversion sequencer for a 10-bit successive-approximation converter with avalon-mm registers
//
// Functional notes
// - done flag sets at every conversion end, regardless of interrupt enable.
// - hardware never clears the done flag; software clears it explicitly.
// - interrupt request raised only when done flag and its enable are both set.
// - a converter interrupt during low-power mode wakes the device.
// - after wake the next instruction runs; vectoring only with global enable.
// - 10-bit result presented left or right justified across result pair.
// - converter works only while its module enable bit is one.
// - writing go starts a conversion; go reads one while converting.
// - on completion go clears, done flag sets, result registers load.
// - clearing go mid-conversion aborts and keeps the previous result.
// - after abort wait two bit periods, then acquisition restarts automatically.
// - reset returns all registers to reset state, converter off, conversion ended.
// - with rc clock, conversion start is delayed one extra instruction cycle.
// - low-power, rc clock, interrupt off: power down after conversion, enable stays.
// - non-rc clock entering low-power mode aborts and powers down, enable stays.
// - special event trigger sets go and resets the timer-one counter.
// - a full conversion takes eleven bit periods, msb first.
// - clock select picks clock over 2, 8, 32, or the rc clock.
// - channel select picks inputs 0..13, voltage reference, fixed reference.
// - justify one is right, zero is left; left puts bits 9..2 high.
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_consts.svh"
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // avalon-mm slave
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // processor side
  input wire logic sleep_i,
  input wire logic global_irq_enable_i,
  output logic irq_o,
  output logic wake_o,
  output logic isr_vector_o,
  // capture unit and timer
  input wire logic special_event_i,
  output logic timer_reset_o,
  // analog core
  input wire logic rc_clk_i,
  input wire logic compare_i,
  output logic conv_power_o,
  output logic sample_o,
  output logic [3:0] channel_sel_o,
  output logic [9:0] dac_code_o
);

  ctrl0_s ctrl0_q;
  conv_state_e state_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic justify_q;
  logic flag_q;
  logic irq_en_q;
  logic pd_q;
  logic [9:0] sar_q;
  logic [9:0] result_q;
  logic [3:0] tad_cnt_q;
  logic [4:0] div_q;
  logic [2:0] insn_q;
  logic irq_q, wake_q, vec_q, trst_q, sample_q;
  logic [1:0] rc_sync_q, cmp_sync_q;
  logic rc_prev_q;
  logic [4:0] div_last;
  logic tad_tick, rc_sel, wr_acc, rd_acc, wr_b0;
  logic wr_ctrl0, sw_start, hw_start, start, sw_stop, sleep_abort, disable_wr;
  logic abort_now, done_evt, flag_clr;
  logic [3:0] bit_idx;
  logic [7:0] res_hi, res_lo;

  // async pins pass two flops before any use; at clock over 2 the synced compare lags a trial
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rc_sync_q <= 2'h0;
      cmp_sync_q <= 2'h0;
      rc_prev_q <= 1'b0;
    end else begin
      rc_sync_q <= {rc_sync_q[0], rc_clk_i};
      cmp_sync_q <= {cmp_sync_q[0], compare_i};
      rc_prev_q <= rc_sync_q[1];
    end
  end

  // bus strobes: one wait cycle, access takes effect when waitrequest is low
  assign wr_acc = write_i & ~wait_q;
  assign rd_acc = read_i & ~wait_q;
  assign wr_b0 = wr_acc & byteenable_i[0];
  assign wr_ctrl0 = wr_b0 & (address_i == `OFF_CTRL0);
  assign flag_clr = wr_b0 & (address_i == `OFF_IRQ_FLAG) & ~writedata_i[`FLAG_DONE_BIT];
  assign disable_wr = wr_ctrl0 & ~writedata_i[`CTRL0_EN_BIT];
  // go may only start on a module that was already enabled
  assign sw_start = wr_ctrl0 & writedata_i[`CTRL0_GO_BIT] & ctrl0_q.enable & ~ctrl0_q.go;
  // trigger timing is the system's concern, no check here
  assign hw_start = special_event_i & ctrl0_q.enable & ~ctrl0_q.go;
  assign start = (sw_start | hw_start) & ~disable_wr & ~pd_q;
  assign sw_stop = wr_ctrl0 & ~writedata_i[`CTRL0_GO_BIT] & ctrl0_q.go;
  assign rc_sel = (ctrl0_q.clock_sel == `CKS_RC);
  assign sleep_abort = sleep_i & ~rc_sel & ctrl0_q.go;
  assign abort_now = (state_q == ST_DELAY || state_q == ST_CONV) & (sw_stop | sleep_abort);
  assign bit_idx = 4'ha - tad_cnt_q;

  // bit period: divided system clock or rising edge of the rc clock
  always_comb begin
    case (ctrl0_q.clock_sel)
      `CKS_DIV2: div_last = `DIV2_LAST;
      `CKS_DIV8: div_last = `DIV8_LAST;
      `CKS_DIV32: div_last = `DIV32_LAST;
      default: div_last = `DIV2_LAST;
    endcase
  end
  assign tad_tick = rc_sel ? (rc_sync_q[1] & ~rc_prev_q) : (div_q == div_last);

  assign done_evt = (state_q == ST_CONV) & tad_tick & (tad_cnt_q == `CONV_LAST_TAD) &
                    ~abort_now & ~disable_wr;

  // divider restarts at every state change so each state sees whole bit periods
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= 5'h00;
    end else if (state_q == ST_IDLE || state_q == ST_DELAY || tad_tick || abort_now) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  // sequencing: idle, rc start delay, eleven bit periods, abort recovery
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      ctrl0_q.go <= 1'b0;
      tad_cnt_q <= 4'h0;
      insn_q <= 3'h0;
      sar_q <= 10'h000;
      result_q <= 10'h000;
    end else if (disable_wr) begin
      state_q <= ST_IDLE;
      ctrl0_q.go <= 1'b0;
    end else if (abort_now) begin
      state_q <= ST_ABORT;
      ctrl0_q.go <= 1'b0;
      tad_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            ctrl0_q.go <= 1'b1;
            sar_q <= `SAR_START;
            tad_cnt_q <= 4'h0;
            insn_q <= 3'h0;
            state_q <= rc_sel ? ST_DELAY : ST_CONV;
          end
        end
        ST_DELAY: begin
          insn_q <= insn_q + 3'h1;
          if (insn_q == `INSN_LAST) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (tad_tick) begin
            tad_cnt_q <= tad_cnt_q + 4'h1;
            if (tad_cnt_q != 4'h0) begin
              // resolve one bit, msb first, then trial the next lower one
              sar_q[bit_idx] <= cmp_sync_q[1];
              if (bit_idx != 4'h0) begin
                sar_q[bit_idx - 4'h1] <= 1'b1;
              end
            end
            if (tad_cnt_q == `CONV_LAST_TAD) begin
              result_q <= {sar_q[9:1], cmp_sync_q[1]};
              ctrl0_q.go <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ABORT: begin
          if (tad_tick) begin
            tad_cnt_q <= tad_cnt_q + 4'h1;
            if (tad_cnt_q[0] == `ABORT_LAST_TAD) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // software-owned control fields; channel codes pass straight to the mux
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl0_q.enable <= 1'b0;
      ctrl0_q.clock_sel <= 2'h0;
      ctrl0_q.channel_sel <= 4'h0;
      justify_q <= 1'b0;
      irq_en_q <= 1'b0;
    end else if (wr_b0) begin
      if (address_i == `OFF_CTRL0) begin
        ctrl0_q.enable <= writedata_i[`CTRL0_EN_BIT];
        ctrl0_q.clock_sel <= writedata_i[`CTRL0_CKS_LSB +: 2];
        ctrl0_q.channel_sel <= writedata_i[`CTRL0_CHS_LSB +: 4];
      end
      if (address_i == `OFF_CTRL1) begin
        justify_q <= writedata_i[`CTRL1_JUST_BIT];
      end
      if (address_i == `OFF_IRQ_EN) begin
        irq_en_q <= writedata_i[`EN_DONE_BIT];
      end
    end
  end

  // done flag: a completion in the clearing cycle wins over the clear
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_q <= 1'b0;
    end else if (done_evt) begin
      flag_q <= 1'b1;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  // low-power power-down; enable bit is left alone, wakes when sleep ends
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pd_q <= 1'b0;
    end else if (!sleep_i) begin
      pd_q <= 1'b0;
    end else if (sleep_abort || (done_evt && rc_sel && !irq_en_q)) begin
      pd_q <= 1'b1;
    end
  end

  // processor-side requests, registered so every output is a flop
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      vec_q <= 1'b0;
      trst_q <= 1'b0;
    end else begin
      irq_q <= flag_q & irq_en_q;
      wake_q <= flag_q & irq_en_q & sleep_i;
      // wake always resumes in line; only the global enable leads to the vector
      vec_q <= flag_q & irq_en_q & global_irq_enable_i;
      trst_q <= special_event_i;
    end
  end

  // analog side: sampling only while powered and idle, so acquisition restarts after a conversion or the abort wait
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_q <= 1'b0;
    end else begin
      sample_q <= ctrl0_q.enable & ~pd_q & (state_q == ST_IDLE);
    end
  end

  // justified views of the held result
  always_comb begin
    if (justify_q) begin
      res_hi = {6'h00, result_q[9:8]};
      res_lo = result_q[7:0];
    end else begin
      res_hi = result_q[9:2];
      res_lo = {result_q[1:0], 6'h00};
    end
  end

  // bus answer: read data latched at the request edge, unmapped reads give zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (wait_q && (read_i || write_i)) begin
      wait_q <= 1'b0;
      case (address_i)
        `OFF_CTRL0: rdata_q <= {24'h000000, ctrl0_q};
        `OFF_CTRL1: rdata_q <= {24'h000000, justify_q, 7'h00};
        `OFF_RES_HI: rdata_q <= {24'h000000, res_hi};
        `OFF_RES_LO: rdata_q <= {24'h000000, res_lo};
        `OFF_IRQ_FLAG: rdata_q <= {31'h00000000, flag_q};
        `OFF_IRQ_EN: rdata_q <= {31'h00000000, irq_en_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign readdata_o = rdata_q;
  assign waitrequest_o = wait_q;
  assign irq_o = irq_q;
  assign wake_o = wake_q;
  assign isr_vector_o = vec_q;
  assign timer_reset_o = trst_q;
  assign conv_power_o = ctrl0_q.enable & ~pd_q;
  assign sample_o = sample_q;
  assign channel_sel_o = ctrl0_q.channel_sel;
  assign dac_code_o = sar_q;

  // cycle count inside a conversion, read only by the checks below
  logic [5:0] conv_cyc_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_cyc_q <= 6'h00;
    end else if (state_q != ST_CONV) begin
      conv_cyc_q <= 6'h00;
    end else begin
      conv_cyc_q <= conv_cyc_q + 6'h01;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  property p_flag_set; done_evt |=> flag_q; endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set");
  property p_flag_hold; flag_q && !flag_clr |=> flag_q; endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("done flag lost");
  property p_irq_gate; !irq_en_q && !flag_q |=> !irq_o; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without cause");
  property p_wake; flag_q && irq_en_q && sleep_i |=> wake_o && irq_o; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_go_busy; state_q == ST_CONV || state_q == ST_DELAY |-> ctrl0_q.go; endproperty
  a_go_busy: assert property (p_go_busy) else $error("go low while busy");
  property p_done; done_evt |=> !ctrl0_q.go && state_q == ST_IDLE ##1 irq_en_q |-> irq_o;
  endproperty
  a_done: assert property (p_done) else $error("completion wrong");
  property p_abort_keep; state_q == ST_ABORT |=> $stable(result_q); endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("result changed");
  property p_abort_len; $rose(state_q == ST_ABORT) |-> (state_q == ST_ABORT)[*4];
  endproperty
  a_abort_len: assert property (p_abort_len) else $error("abort wait short");
  property p_rc_delay; state_q == ST_IDLE && start && rc_sel && !disable_wr |=>
    (state_q == ST_DELAY)[*4] ##1 (state_q == ST_CONV || state_q == ST_ABORT);
  endproperty
  a_rc_delay: assert property (p_rc_delay) else $error("rc start delay");
  property p_conv_len; done_evt && ctrl0_q.clock_sel == `CKS_DIV2 |-> conv_cyc_q == 6'h15;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("eleven periods");
  property p_trig; hw_start && state_q == ST_IDLE && !disable_wr && !pd_q |=>
    ctrl0_q.go && timer_reset_o;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger missed");
  property p_sleep; sleep_abort && state_q == ST_CONV && !disable_wr |=>
    state_q == ST_ABORT && !conv_power_o && ctrl0_q.enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep abort");
  property p_off; !ctrl0_q.enable |-> state_q == ST_IDLE && !ctrl0_q.go; endproperty
  a_off: assert property (p_off) else $error("busy while off");

  c_done: cover property (done_evt ##[1:40] flag_clr);
  c_abort: cover property (sw_stop && state_q == ST_CONV);
  c_rc: cover property (state_q == ST_DELAY ##[1:8] done_evt);
  c_trig: cover property (hw_start ##[1:100] done_evt);

endmodule : adc_conversion_sequencer
`default_nettype wire

// file: test/adc_analog_model.sv
// behavioural model of the comparator and rc oscillator
`timescale 1ns/100ps
`default_nettype none
module adc_analog_model (
  // digital side
  input wire logic clock_i,
  input wire logic power_i,
  input wire logic [3:0] channel_i,
  input wire logic [9:0] code_i,
  input wire logic [15:0][9:0] level_i,
  // analog side
  output logic compare_o,
  output logic rc_clk_o
);
  logic junk_q = 1'b0;
  // an unpowered comparator means nothing, so it flips every cycle
  always @(posedge clock_i) begin
    junk_q <= ~junk_q;
  end
  // high keeps the trial bit: input at or above the trial code
  assign compare_o = power_i ? (level_i[channel_i] >= code_i) : junk_q;
  // oscillator stands still while unpowered; phase unrelated to clock_i
  initial begin
    rc_clk_o = 1'b0;
    forever begin
      #23.3;
      rc_clk_o = power_i ? ~rc_clk_o : 1'b0;
    end
  end
endmodule : adc_analog_model
`default_nettype wire

// file: test/tb.sv
// self-checking testbench of the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_consts.svh"
module tb
  import adc_seq_pkg::*;
;
  logic clock_i, rstn_i, read_i, write_i, sleep_i, global_irq_enable_i, special_event_i;
  logic [4:0] address_i;
  logic [3:0] byteenable_i;
  logic [31:0] writedata_i, readdata_o, rd;
  logic waitrequest_o, irq_o, wake_o, isr_vector_o, timer_reset_o, rc_clk_i, compare_i;
  logic conv_power_o, sample_o;
  logic [3:0] channel_sel_o;
  logic [9:0] dac_code_o;
  logic [15:0][9:0] level;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  adc_conversion_sequencer uut (.clock_i, .rstn_i, .address_i, .read_i, .write_i,
    .byteenable_i, .writedata_i, .readdata_o, .waitrequest_o, .sleep_i,
    .global_irq_enable_i, .irq_o, .wake_o, .isr_vector_o, .special_event_i,
    .timer_reset_o, .rc_clk_i, .compare_i, .conv_power_o, .sample_o, .channel_sel_o,
    .dac_code_o);
  adc_analog_model core (.clock_i, .power_i(conv_power_o), .channel_i(channel_sel_o),
    .code_i(dac_code_o), .level_i(level), .compare_o(compare_i), .rc_clk_o(rc_clk_i));
  // clock and a free cycle count for timing checks
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) cyc <= cyc + 1;
  function automatic logic [7:0] c0(input logic [1:0] k, input logic [3:0] ch, input logic g);
    ctrl0_s s;
    s = '{clock_sel: k, channel_sel: ch, go: g, enable: 1'b1};
    return s;
  endfunction : c0
  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    address_i <= a;
    writedata_i <= {24'h0, d};
    write_i <= wr;
    read_i <= ~wr;
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    if (n >= 50) begin
      fails++;
      $display("ERROR waitrequest expected 0 seen 1");
    end
  endtask : bus
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic pin(input string name, input logic e, input logic g);
    chk(name, {31'h0, e}, {31'h0, g});
  endtask : pin
  task automatic rchk(input string name, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(name, {24'h0, e}, rd);
  endtask : rchk
  // polls go until it clears; t is the cycles spent
  task automatic wait_idle(output int t);
    int t0, n;
    t0 = cyc;
    n = 0;
    do begin
      bus(1'b0, `OFF_CTRL0, 8'h00);
      n++;
    end while (rd[`CTRL0_GO_BIT] !== 1'b0 && n < 400);
    t = cyc - t0;
    if (n >= 400) begin
      fails++;
      $display("ERROR go expected 0 seen 1");
    end
  endtask : wait_idle
  // channel first, settle, then go in a later write
  task automatic start(input logic [1:0] k, input logic [3:0] ch);
    bus(1'b1, `OFF_CTRL0, c0(k, ch, 1'b0));
    repeat (8) @(posedge clock_i);
    bus(1'b1, `OFF_CTRL0, c0(k, ch, 1'b1));
  endtask : start
  // result in both formats, format applied when read
  task automatic res_chk(input logic [9:0] r);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, `OFF_CTRL1, {j[0], 7'h00});
      rchk("result high", `OFF_RES_HI, j ? {6'h00, r[9:8]} : r[9:2]);
      rchk("result low", `OFF_RES_LO, j ? r[7:0] : {r[1:0], 6'h00});
    end
  endtask : res_chk
  task automatic clr_flag();
    bus(1'b1, `OFF_IRQ_FLAG, 8'h00);
  endtask : clr_flag
  task automatic t_reset();
    pin("power off", 1'b0, conv_power_o);
    rchk("ctrl0", `OFF_CTRL0, 8'h00);
    rchk("ctrl1", `OFF_CTRL1, 8'h00);
    rchk("flag", `OFF_IRQ_FLAG, 8'h00);
    rchk("irq enable", `OFF_IRQ_EN, 8'h00);
    bus(1'b1, 5'h1c, 8'hff);
    rchk("unmapped", 5'h1c, 8'h00);
    bus(1'b1, `OFF_CTRL0, c0(`CKS_DIV2, 4'h0, 1'b1));
    rchk("go with enable", `OFF_CTRL0, c0(`CKS_DIV2, 4'h0, 1'b0));
    pin("acquiring", 1'b1, sample_o);
    $display("test reset done");
  endtask : t_reset
  task automatic t_basic();
    int t;
    start(`CKS_DIV8, 4'h3);
    rchk("go busy", `OFF_CTRL0, c0(`CKS_DIV8, 4'h3, 1'b1));
    wait_idle(t);
    rchk("flag set", `OFF_IRQ_FLAG, 8'h01);
    pin("irq masked", 1'b0, irq_o);
    res_chk(level[3]);
    bus(1'b1, `OFF_IRQ_FLAG, 8'h01);
    repeat (20) @(posedge clock_i);
    rchk("flag kept", `OFF_IRQ_FLAG, 8'h01);
    clr_flag();
    rchk("flag cleared", `OFF_IRQ_FLAG, 8'h00);
    $display("test basic done");
  endtask : t_basic
  task automatic t_clocks();
    int t, dv;
    for (int k = 0; k < 3; k++) begin
      dv = 2 << (2 * k);
      // clock over 2 runs on a rail level, where the synced compare lag cannot show
      start(k[1:0], 4'(15 - k));
      chk("channel", 32'(15 - k), {28'h0, channel_sel_o});
      wait_idle(t);
      pin("period count", 1'b1, t > 10 * dv && t <= 11 * dv + 10);
      res_chk(level[15 - k]);
      clr_flag();
    end
    $display("test clocks done");
  endtask : t_clocks
  task automatic t_abort();
    start(`CKS_DIV32, 4'h2);
    repeat (60) @(posedge clock_i);
    bus(1'b1, `OFF_CTRL0, c0(`CKS_DIV32, 4'h2, 1'b0));
    repeat (15) @(posedge clock_i);
    pin("abort wait", 1'b0, sample_o);
    repeat (65) @(posedge clock_i);
    pin("acquire again", 1'b1, sample_o);
    chk("channel", 32'h2, {28'h0, channel_sel_o});
    rchk("no flag", `OFF_IRQ_FLAG, 8'h00);
    res_chk(level[13]);
    $display("test abort done");
  endtask : t_abort
  task automatic t_wake();
    int n;
    bus(1'b1, `OFF_IRQ_EN, 8'h01);
    rchk("irq enable", `OFF_IRQ_EN, 8'h01);
    global_irq_enable_i <= 1'b1;
    start(`CKS_RC, 4'h5);
    sleep_i <= 1'b1;
    n = 0;
    while (wake_o !== 1'b1 && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
    pin("wake", 1'b1, wake_o);
    pin("irq", 1'b1, irq_o);
    pin("vector", 1'b1, isr_vector_o);
    sleep_i <= 1'b0;
    global_irq_enable_i <= 1'b0;
    res_chk(level[5]);
    pin("no vector", 1'b0, isr_vector_o);
    clr_flag();
    repeat (3) @(posedge clock_i);
    pin("irq cleared", 1'b0, irq_o);
    $display("test wake done");
  endtask : t_wake
  task automatic t_sleep();
    int t;
    bus(1'b1, `OFF_IRQ_EN, 8'h00);
    start(`CKS_RC, 4'h6);
    sleep_i <= 1'b1;
    wait_idle(t);
    rchk("flag", `OFF_IRQ_FLAG, 8'h01);
    repeat (2) @(posedge clock_i);
    pin("powered down", 1'b0, conv_power_o);
    pin("no wake", 1'b0, wake_o);
    rchk("enable kept", `OFF_CTRL0, c0(`CKS_RC, 4'h6, 1'b0));
    sleep_i <= 1'b0;
    res_chk(level[6]);
    clr_flag();
    start(`CKS_DIV32, 4'h7);
    repeat (40) @(posedge clock_i);
    sleep_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    pin("sleep abort", 1'b0, conv_power_o);
    rchk("enable kept", `OFF_CTRL0, c0(`CKS_DIV32, 4'h7, 1'b0));
    repeat (80) @(posedge clock_i);
    rchk("no flag", `OFF_IRQ_FLAG, 8'h00);
    sleep_i <= 1'b0;
    repeat (80) @(posedge clock_i);
    res_chk(level[6]);
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_trigger();
    int t;
    bus(1'b1, `OFF_CTRL0, c0(`CKS_DIV8, 4'h9, 1'b0));
    repeat (8) @(posedge clock_i);
    special_event_i <= 1'b1;
    @(posedge clock_i);
    special_event_i <= 1'b0;
    @(posedge clock_i);
    pin("timer reset", 1'b1, timer_reset_o);
    @(posedge clock_i);
    pin("timer pulse", 1'b0, timer_reset_o);
    rchk("go by trigger", `OFF_CTRL0, c0(`CKS_DIV8, 4'h9, 1'b1));
    wait_idle(t);
    rchk("flag", `OFF_IRQ_FLAG, 8'h01);
    res_chk(level[9]);
    $display("test trigger done");
  endtask : t_trigger
  task automatic t_reset_mid();
    start(`CKS_DIV32, 4'h4);
    repeat (50) @(posedge clock_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    pin("off in reset", 1'b0, conv_power_o);
    pin("no acquire", 1'b0, sample_o);
    rstn_i <= 1'b1;
    rchk("ctrl0", `OFF_CTRL0, 8'h00);
    rchk("flag", `OFF_IRQ_FLAG, 8'h00);
    $display("test reset mid done");
  endtask : t_reset_mid
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // cuts a hang short well beyond the expected run
  initial begin
    repeat (40000) @(posedge clock_i);
    fails++;
    $display("ERROR watchdog expected end seen hang");
    finish_test();
  end
  // main sequence; edge levels on channels 14 and 15
  initial begin
    for (int i = 0; i < 16; i++) level[i] = 10'(i * 71 + 7);
    level[14] = 10'h3ff;
    level[15] = 10'h000;
    {rstn_i, read_i, write_i, sleep_i, global_irq_enable_i, special_event_i} = 6'h00;
    address_i = 5'h00;
    writedata_i = 32'h0;
    byteenable_i = 4'hf;
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_reset();
    t_basic();
    t_clocks();
    t_abort();
    t_wake();
    t_sleep();
    t_trigger();
    t_reset_mid();
    finish_test();
  end
endmodule : tb
`default_nettype wire
